// ### test/vccr_regs_sva.sv
/*
 * Port checker for the calibration control register bank.
 * Assumes it is bound to vccr_regs and sees only that module's ports.
 */
module vccr_regs_sva
	import vccr_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rd_valid,
	input wire logic       reg_miss,
	input wire logic       pfd_tick,
	input wire logic       test_mode_en,
	input wire logic [7:0] cal_band,
	input wire logic       regulator_supply_select,
	input wire logic       core_a_rectifier_bias,
	input wire logic       core_a_lower_threshold_range,
	input wire logic [2:0] core_a_nominal_threshold,
	input wire logic [7:0] autocal_stage_time,
	input wire logic [9:0] wait_timeout,
	input wire logic [4:0] synthetic_lock_wait,
	input wire logic [4:0] level_loop_settle_wait,
	input wire logic       converter_tune_select,
	input wire logic       converter_fast_mode,
	input wire logic       converter_power,
	input wire logic       converter_clk_tick,
	input wire logic [7:0] osc_band
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	wire unmapped = reg_addr < 8'h2F || reg_addr > 8'h39;

	////////////////////////////////////////////////////////////////
	AST_UNMAPPED_RD: assert property (reg_rd && unmapped |=>
		reg_rd_valid && reg_miss && reg_rdata == 8'h00)
		else $error("unmapped read not refused");
	AST_MAPPED_HIT: assert property ((reg_rd || reg_wr) && !unmapped |=> !reg_miss)
		else $error("miss flagged on mapped address");
	AST_RSVD_ZERO: assert property (reg_rd && reg_addr == 8'h33 |=>
		reg_rdata[7:5] == 3'b000)
		else $error("reserved bits read nonzero");
	AST_CORE_A: assert property (reg_wr && reg_addr == 8'h2F |-> ##2
		{regulator_supply_select, core_a_rectifier_bias, core_a_lower_threshold_range,
		core_a_nominal_threshold} == {$past(reg_wdata[7], 2), $past(reg_wdata[4:0], 2)})
		else $error("core A fields wrong after write");
	AST_STAGE: assert property (reg_wr && reg_addr == 8'h30 |-> ##2
		autocal_stage_time == $past(reg_wdata, 2))
		else $error("stage time wrong after write");
	AST_WAIT_LOW: assert property (reg_wr && reg_addr == 8'h31 |-> ##2
		wait_timeout[7:0] == $past(reg_wdata, 2))
		else $error("timeout low byte wrong");
	AST_CONV: assert property (reg_wr && reg_addr == 8'h32 |-> ##2
		converter_tune_select == $past(reg_wdata[7], 2) &&
		converter_fast_mode == $past(reg_wdata[5], 2) &&
		converter_power == $past(reg_wdata[2], 2) &&
		wait_timeout[9:8] == $past(reg_wdata[1:0], 2))
		else $error("converter control fields wrong");
	AST_SYNTH: assert property (reg_wr && reg_addr == 8'h33 |-> ##2
		synthetic_lock_wait == $past(reg_wdata[4:0], 2))
		else $error("synthetic lock wait wrong");
	AST_LEVEL: assert property (reg_wr && reg_addr == 8'h34 |-> ##2
		level_loop_settle_wait == $past(reg_wdata[4:0], 2))
		else $error("level loop wait wrong");
	AST_TICK_CAUSE: assert property (converter_clk_tick |-> $past(pfd_tick))
		else $error("converter tick without phase detector tick");
	AST_NORMAL_BAND: assert property (!test_mode_en |=> osc_band == $past(cal_band))
		else $error("band not from calibration in normal mode");

	////////////////////////////////////////////////////////////////
	COV_CONV_WR: cover property (reg_wr && reg_addr == 8'h32);
	COV_MISS: cover property (reg_miss);
	COV_TICK: cover property (converter_clk_tick);
endmodule : vccr_regs_sva

bind vccr_regs vccr_regs_sva vccr_regs_sva_inst (.clk_sys, .resetn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .reg_miss, .pfd_tick, .test_mode_en,
	.cal_band, .regulator_supply_select, .core_a_rectifier_bias,
	.core_a_lower_threshold_range, .core_a_nominal_threshold, .autocal_stage_time,
	.wait_timeout, .synthetic_lock_wait, .level_loop_settle_wait, .converter_tune_select,
	.converter_fast_mode, .converter_power, .converter_clk_tick, .osc_band);

// ### test/vccr_regs_tb.sv
/*
 * Self-checking bench for the calibration control register bank.
 * Assumes the one-cycle strobe access of the serial port front end.
 */
module vccr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vccr_pkg::*;

	logic       clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       pfd_tick = 1'b0, test_mode_en = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cal_band = 8'h5A;
	logic [3:0] cal_core = 4'h8, cal_bias = 4'h3;
	logic [7:0] reg_rdata, autocal_stage_time, pump_current_offset, osc_band;
	logic       reg_rd_valid, reg_miss, regulator_supply_select, core_a_rectifier_bias;
	logic       core_a_lower_threshold_range, converter_tune_select, converter_fast_mode;
	logic       converter_continuous_mode, converter_convert, converter_start;
	logic       converter_power, converter_clk_tick, test_core_code_bad;
	logic [2:0] core_a_nominal_threshold, cal_machine_test_modes, test_mux_select;
	logic [9:0] wait_timeout;
	logic [4:0] synthetic_lock_wait, level_loop_settle_wait;
	logic [3:0] test_tune_target, osc_core, osc_bias;
	int         errors = 0, comparisons = 0;
	wire [5:0]  core_a_f = {regulator_supply_select, core_a_rectifier_bias,
		core_a_lower_threshold_range, core_a_nominal_threshold};
	wire [4:0]  conv_f = {converter_tune_select, converter_fast_mode,
		converter_continuous_mode, converter_convert, converter_power};
	logic [7:0] conv_vals [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h0C};
	logic [7:0] bad [4] = '{8'h2E, 8'h3A, 8'h00, 8'hFF};
	logic [3:0] cores [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

	vccr_regs vccr_regs_inst (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reg_rd_valid, .reg_miss, .pfd_tick, .test_mode_en, .cal_band,
		.cal_core, .cal_bias, .regulator_supply_select, .core_a_rectifier_bias,
		.core_a_lower_threshold_range, .core_a_nominal_threshold, .autocal_stage_time,
		.wait_timeout, .synthetic_lock_wait, .level_loop_settle_wait,
		.cal_machine_test_modes, .converter_tune_select, .converter_fast_mode,
		.converter_continuous_mode, .converter_convert, .converter_start, .converter_power,
		.converter_clk_tick, .pump_current_offset, .test_mux_select, .test_tune_target,
		.osc_band, .osc_core, .osc_bias, .test_core_code_bad);

	always #12.5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// returns at the falling edge where the field outputs have settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk(reg_rd_valid, 1'b1, "rd_valid");
		chk(reg_rdata, exp, "rdata");
		chk(reg_miss, a < 8'h2F || a > 8'h39, "miss");
	endtask : rd

	task automatic do_reset();
		@(negedge clk_sys);
		resetn = 1'b0;
		repeat (16) @(negedge clk_sys);
		resetn = 1'b1;
	endtask : do_reset

	task automatic defaults();
		chk(core_a_f, 6'b110010, "core_a");
		chk(autocal_stage_time, 8'h3F, "stage");
		chk(wait_timeout, 10'h0A7, "timeout");
		chk(conv_f, 5'b00001, "conv");
		chk(synthetic_lock_wait, 5'h0C, "synth");
		chk(level_loop_settle_wait, 5'h1E, "level");
		chk(cal_machine_test_modes, 3'h4, "test_modes");
		chk(pump_current_offset, 8'h30, "pump");
		chk(test_mux_select, 3'h0, "mux");
		chk(test_tune_target, 4'h7, "tune");
		for (int i = 0; i < VCCR_NREG; i++) begin
			rd(VCCR_OFFSET[i], VCCR_RESET[i]);
		end
	endtask : defaults

	// pfd every cycle, so the tick spacing in cycles equals the divide ratio
	task automatic period(input logic [7:0] d);
		int n;
		wr(8'h35, d);
		pfd_tick = 1'b1;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (converter_clk_tick !== 1'b1 && n < 2000);
		end
		pfd_tick = 1'b0;
		chk(16'(n), 16'(d * 4 + 2), "adc period");
	endtask : period

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		defaults();
		for (int i = 0; i < VCCR_NREG; i++) begin
			wr(VCCR_OFFSET[i], 8'hFF);
			rd(VCCR_OFFSET[i], VCCR_WMASK[i]);
		end
		chk(cal_machine_test_modes, 3'h7, "test_modes");
		chk(pump_current_offset, 8'hFF, "pump");
		chk(test_mux_select, 3'h7, "mux");
		chk(test_tune_target, 4'hF, "tune");
		wr(8'h2F, 8'h1D);
		chk(core_a_f, 6'b011101, "core_a");
		wr(8'h2F, 8'h82);
		chk(core_a_f, 6'b100010, "core_a");
		wr(8'h30, 8'h01);
		chk(autocal_stage_time, 8'h01, "stage");
		wr(8'h31, 8'h00);
		wr(8'h32, 8'h03);
		chk(wait_timeout, 10'h300, "timeout");
		wr(8'h31, 8'hFF);
		chk(wait_timeout, 10'h3FF, "timeout");
		wr(8'h33, 8'hF3);
		chk(synthetic_lock_wait, 5'h13, "synth");
		rd(8'h33, 8'h13);
		wr(8'h34, 8'hA1);
		chk(level_loop_settle_wait, 5'h01, "level");
		foreach (conv_vals[i]) begin
			wr(8'h32, conv_vals[i]);
			chk(conv_f, {conv_vals[i][7], conv_vals[i][5:2]}, "conv");
			chk(converter_start, conv_vals[i] == 8'h0C, "start");
		end
		foreach (bad[i]) begin
			wr(bad[i], 8'hFF);
			rd(bad[i], 8'h00);
		end
		rd(8'h2F, 8'h82);
		rd(8'h39, 8'h7F);
		chk(osc_band, 8'h5A, "band");
		wr(8'h37, 8'hC3);
		test_mode_en = 1'b1;
		foreach (cores[i]) begin
			wr(8'h38, {cores[i], {4{i[0]}}});
			@(negedge clk_sys);
			chk(osc_band, 8'hC3, "band");
			chk(osc_core, cores[i], "core");
			chk(osc_bias, {4{i[0]}}, "bias");
			chk(test_core_code_bad, 1'b0, "core_bad");
		end
		wr(8'h38, 8'h30);
		@(negedge clk_sys);
		chk(osc_core, 4'h0, "core");
		chk(test_core_code_bad, 1'b1, "core_bad");
		test_mode_en = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(osc_core, 4'h8, "core");
		period(8'h00);
		period(8'h01);
		period(8'h4C);
		do_reset();
		defaults();
		summarize();
	end

	// the sequence needs about 1200 cycles (some 30 us); this is well beyond that
	initial begin
		#500us;
		errors++;
		summarize();
	end
endmodule : vccr_regs_tb

// ### verilog/vccr_clk_div.sv
/*
 * Converter clock divider: turns the phase detector tick into a converter
 * clock tick every divider*4+2 phase detector ticks.
 * Assumes pfd_tick is a one-cycle enable in the clk_sys domain.
 */
module vccr_clk_div
	import vccr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 pfd_tick,
	input  wire logic [7:0]           div_value,
	output logic                      conv_tick
);
	import vccr_pkg::*;

	logic [W_DIV_CNT-1:0] count;
	logic [W_DIV_CNT-1:0] period;

	assign period = W_DIV_CNT'({2'b00, div_value} * DIV_MUL + DIV_ADD);

	////////////////////////////////////////////////////////////////////////////
	// a shrunk divider value wraps at once rather than running to overflow
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			count     <= '0;
			conv_tick <= 1'b0;
		end else begin
			conv_tick <= 1'b0;
			if (pfd_tick) begin
				if (count >= period - W_DIV_CNT'(1)) begin
					count     <= '0;
					conv_tick <= 1'b1;
				end else begin
					count <= count + W_DIV_CNT'(1);
				end
			end
		end
	end

endmodule : vccr_clk_div

// ### verilog/vccr_pkg.sv
/*
 * Constants for the oscillator calibration control register bank: register
 * offsets, write masks, reset values, field positions and divider figures.
 * Assumes the serial port in front of the bank presents whole 8-bit
 * register accesses with an 8-bit address.
 */
// Function
// - Bit 7 of the regulator/core A register selects the oscillator regulator supply (0 3.3 V, 1 5 V), reset 1.
// - Bit 4 of that register sets core A rectifier DC bias (0 3.3 V, 1 5 V), reset 1.
// - Bit 3 of that register selects core A lower threshold range (0 5 V, 1 3.3 V), reset 0.
// - Bits 2..0 hold core A nominal threshold, reset 2, and software writes 010 for either supply.
// - An 8-bit register sets the time of each autocalibration stage, reset 0x3F.
// - A 10-bit wait timeout is built from an 8-bit register (reset 0xA7) and bits 1..0 of converter control (reset 0).
// - Bit 7 of converter control routes temperature voltage (0) or scaled tuning voltage (1) to the converter.
// - Bit 5 of converter control enables fast conversion and bit 4 continuous conversion, both reset off.
// - Bit 3 of converter control requests a conversion and bit 2 powers the converter, reset on.
// - Bits 4..0 of one register hold the synthetic lock wait, reset 0xC.
// - Bits 4..0 of another register hold the level loop settle wait, reset 0x1E.
// - The converter clock is the phase detector rate divided by divider*4+2, divider reset 0x4C, aimed at 100 kHz.
// - In test mode an 8-bit register picks the band in the active core, reset 0.
// - In test mode bits 7..4 pick one core one-hot: 0 none, 1 D, 10 C, 100 B, 1000 A.
// - In test mode bits 3..0 set oscillator bias, 0000 maximum and 1111 minimum.
package vccr_pkg;

	localparam int VCCR_NREG = 11;
	localparam int VCCR_IDXW = 4;

	// register index order
	localparam logic [3:0] IX_REG_CORE_A  = 4'h0;
	localparam logic [3:0] IX_STAGE_TIME  = 4'h1;
	localparam logic [3:0] IX_WAIT_LOW    = 4'h2;
	localparam logic [3:0] IX_CONV_CTRL   = 4'h3;
	localparam logic [3:0] IX_SYNTH_LOCK  = 4'h4;
	localparam logic [3:0] IX_LEVEL_LOOP  = 4'h5;
	localparam logic [3:0] IX_CONV_DIV    = 4'h6;
	localparam logic [3:0] IX_PUMP_OFFSET = 4'h7;
	localparam logic [3:0] IX_TEST_BAND   = 4'h8;
	localparam logic [3:0] IX_TEST_CORE   = 4'h9;
	localparam logic [3:0] IX_TEST_MUX    = 4'hA;

	localparam logic [7:0] VCCR_OFFSET [VCCR_NREG] = '{
		8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39
	};
	localparam logic [7:0] VCCR_RESET [VCCR_NREG] = '{
		8'h92, 8'h3F, 8'hA7, 8'h04, 8'h0C, 8'h9E, 8'h4C, 8'h30, 8'h00, 8'h00, 8'h07
	};
	// writable bits; all others are reserved
	localparam logic [7:0] VCCR_WMASK [VCCR_NREG] = '{
		8'h9F, 8'hFF, 8'hFF, 8'hBF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F
	};

	// regulator / core A fields
	localparam int POS_SUPPLY_SEL = 7;
	localparam int POS_RECT_BIAS  = 4;
	localparam int POS_LOW_RANGE  = 3;
	localparam int POS_NOM_LSB    = 0;
	localparam int W_NOM          = 3;

	// converter control fields
	localparam int POS_CONV_MUX   = 7;
	localparam int POS_CONV_FAST  = 5;
	localparam int POS_CONV_CONT  = 4;
	localparam int POS_CONV_GO    = 3;
	localparam int POS_CONV_PWR   = 2;
	localparam int POS_WAIT_HI    = 0;
	localparam int W_WAIT_HI      = 2;
	localparam int W_WAIT         = 10;

	// wait fields, test fields
	localparam int W_WAIT5        = 5;
	localparam int POS_TEST_MODES = 5;
	localparam int W_TEST_MODES   = 3;
	localparam int POS_CORE_LSB   = 4;
	localparam int W_CORE         = 4;
	localparam int POS_BIAS_LSB   = 0;
	localparam int W_BIAS         = 4;
	localparam int POS_MUX_LSB    = 4;
	localparam int W_MUX          = 3;
	localparam int POS_TUNE_LSB   = 0;
	localparam int W_TUNE         = 4;

	// converter clock: period in phase detector ticks = div*MUL+ADD
	localparam int DIV_MUL        = 4;
	localparam int DIV_ADD        = 2;
	localparam int W_DIV_CNT      = 10;

endpackage : vccr_pkg

// ### verilog/vccr_regs.sv
/*
 * Oscillator calibration control register bank, offsets 0x2F to 0x39.
 * Holds the core A level loop settings, the regulator supply select, the
 * calibration timeouts, the converter controls and divider, and the
 * test-mode overrides, and drives them out as fields.
 * Assumes the serial port in front delivers one-cycle read and write
 * strobes with a stable address and data, and that the calibration
 * machine and converter sit outside.
 */
module vccr_regs
	import vccr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// register access from the serial port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	output logic                      reg_rd_valid,
	output logic                      reg_miss,
	// timing input and calibration machine values
	input  wire logic                 pfd_tick,
	input  wire logic                 test_mode_en,
	input  wire logic [7:0]           cal_band,
	input  wire logic [W_CORE-1:0]    cal_core,
	input  wire logic [W_BIAS-1:0]    cal_bias,
	// regulator and core A level loop
	output logic                      regulator_supply_select,
	output logic                      core_a_rectifier_bias,
	output logic                      core_a_lower_threshold_range,
	output logic [W_NOM-1:0]          core_a_nominal_threshold,
	// calibration timing
	output logic [7:0]                autocal_stage_time,
	output logic [W_WAIT-1:0]         wait_timeout,
	output logic [W_WAIT5-1:0]        synthetic_lock_wait,
	output logic [W_WAIT5-1:0]        level_loop_settle_wait,
	output logic [W_TEST_MODES-1:0]   cal_machine_test_modes,
	// converter
	output logic                      converter_tune_select,
	output logic                      converter_fast_mode,
	output logic                      converter_continuous_mode,
	output logic                      converter_convert,
	output logic                      converter_start,
	output logic                      converter_power,
	output logic                      converter_clk_tick,
	// reserved trims and test outputs
	output logic [7:0]                pump_current_offset,
	output logic [W_MUX-1:0]          test_mux_select,
	output logic [W_TUNE-1:0]         test_tune_target,
	output logic [7:0]                osc_band,
	output logic [W_CORE-1:0]         osc_core,
	output logic [W_BIAS-1:0]         osc_bias,
	output logic                      test_core_code_bad
);
	import vccr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	typedef struct packed {
		logic                 hit;
		logic [VCCR_IDXW-1:0] idx;
	} vccr_dec_t;

	function automatic vccr_dec_t vccr_decode(input logic [7:0] addr);
		vccr_dec_t d;
		d.hit = 1'b0;
		d.idx = '0;
		for (int i = 0; i < VCCR_NREG; i++) begin
			if (addr == VCCR_OFFSET[i]) begin
				d.hit = 1'b1;
				d.idx = VCCR_IDXW'(i);
			end
		end
		return d;
	endfunction : vccr_decode

	vccr_dec_t wr_dec;
	vccr_dec_t rd_dec;

	assign wr_dec = vccr_decode(reg_addr);
	assign rd_dec = vccr_decode(reg_addr);

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0] regs [VCCR_NREG];

	generate
		for (genvar g = 0; g < VCCR_NREG; g++) begin : g_reg
			// reserved bits stay zero because writes are masked with VCCR_WMASK and their reset value is zero
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					regs[g] <= VCCR_RESET[g];
				end else if (reg_wr && wr_dec.hit && wr_dec.idx == VCCR_IDXW'(g)) begin
					regs[g] <= reg_wdata & VCCR_WMASK[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, unmapped reads give zero

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata    <= '0;
			reg_rd_valid <= 1'b0;
			reg_miss     <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd;
			reg_miss     <= (reg_rd || reg_wr) && !rd_dec.hit;
			if (reg_rd) begin
				reg_rdata <= rd_dec.hit ? (regs[rd_dec.idx] & VCCR_WMASK[rd_dec.idx])
				                        : 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// regulator and core A level loop

	logic [7:0] r_core_a;

	assign r_core_a = regs[IX_REG_CORE_A];

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			regulator_supply_select      <= VCCR_RESET[IX_REG_CORE_A][POS_SUPPLY_SEL];
			core_a_rectifier_bias        <= VCCR_RESET[IX_REG_CORE_A][POS_RECT_BIAS];
			core_a_lower_threshold_range <= VCCR_RESET[IX_REG_CORE_A][POS_LOW_RANGE];
			core_a_nominal_threshold     <= VCCR_RESET[IX_REG_CORE_A][POS_NOM_LSB +: W_NOM];
		end else begin
			regulator_supply_select      <= r_core_a[POS_SUPPLY_SEL];
			core_a_rectifier_bias        <= r_core_a[POS_RECT_BIAS];
			core_a_lower_threshold_range <= r_core_a[POS_LOW_RANGE];
			core_a_nominal_threshold     <= r_core_a[POS_NOM_LSB +: W_NOM];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// calibration timing

	logic [7:0] r_conv;

	assign r_conv = regs[IX_CONV_CTRL];

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			autocal_stage_time     <= VCCR_RESET[IX_STAGE_TIME];
			wait_timeout           <= {VCCR_RESET[IX_CONV_CTRL][POS_WAIT_HI +: W_WAIT_HI],
			                           VCCR_RESET[IX_WAIT_LOW]};
			synthetic_lock_wait    <= VCCR_RESET[IX_SYNTH_LOCK][W_WAIT5-1:0];
			level_loop_settle_wait <= VCCR_RESET[IX_LEVEL_LOOP][W_WAIT5-1:0];
			cal_machine_test_modes <= VCCR_RESET[IX_LEVEL_LOOP][POS_TEST_MODES +: W_TEST_MODES];
		end else begin
			autocal_stage_time     <= regs[IX_STAGE_TIME];
			wait_timeout           <= {r_conv[POS_WAIT_HI +: W_WAIT_HI],
			                           regs[IX_WAIT_LOW]};
			synthetic_lock_wait    <= regs[IX_SYNTH_LOCK][W_WAIT5-1:0];
			level_loop_settle_wait <= regs[IX_LEVEL_LOOP][W_WAIT5-1:0];
			cal_machine_test_modes <= regs[IX_LEVEL_LOOP][POS_TEST_MODES +: W_TEST_MODES];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// converter controls

	logic conv_go_d;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			converter_tune_select     <= VCCR_RESET[IX_CONV_CTRL][POS_CONV_MUX];
			converter_fast_mode       <= VCCR_RESET[IX_CONV_CTRL][POS_CONV_FAST];
			converter_continuous_mode <= VCCR_RESET[IX_CONV_CTRL][POS_CONV_CONT];
			converter_convert         <= VCCR_RESET[IX_CONV_CTRL][POS_CONV_GO];
			converter_power           <= VCCR_RESET[IX_CONV_CTRL][POS_CONV_PWR];
		end else begin
			converter_tune_select     <= r_conv[POS_CONV_MUX];
			converter_fast_mode       <= r_conv[POS_CONV_FAST];
			converter_continuous_mode <= r_conv[POS_CONV_CONT];
			converter_convert         <= r_conv[POS_CONV_GO];
			converter_power           <= r_conv[POS_CONV_PWR];
		end
	end

	// start pulse on the rising edge of the request, only while powered
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			conv_go_d       <= 1'b0;
			converter_start <= 1'b0;
		end else begin
			conv_go_d       <= r_conv[POS_CONV_GO];
			converter_start <= r_conv[POS_CONV_GO] && !conv_go_d
			                   && r_conv[POS_CONV_PWR];
		end
	end

	vccr_clk_div u_clk_div (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.pfd_tick  (pfd_tick),
		.div_value (regs[IX_CONV_DIV]),
		.conv_tick (converter_clk_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// reserved trims and test-mode overrides

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pump_current_offset <= VCCR_RESET[IX_PUMP_OFFSET];
			test_mux_select     <= VCCR_RESET[IX_TEST_MUX][POS_MUX_LSB +: W_MUX];
			test_tune_target    <= VCCR_RESET[IX_TEST_MUX][POS_TUNE_LSB +: W_TUNE];
		end else begin
			pump_current_offset <= regs[IX_PUMP_OFFSET];
			test_mux_select     <= regs[IX_TEST_MUX][POS_MUX_LSB +: W_MUX];
			test_tune_target    <= regs[IX_TEST_MUX][POS_TUNE_LSB +: W_TUNE];
		end
	end

	vccr_test_override u_override (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.test_mode_en  (test_mode_en),
		.test_band     (regs[IX_TEST_BAND]),
		.test_core     (regs[IX_TEST_CORE][POS_CORE_LSB +: W_CORE]),
		.test_bias     (regs[IX_TEST_CORE][POS_BIAS_LSB +: W_BIAS]),
		.cal_band      (cal_band),
		.cal_core      (cal_core),
		.cal_bias      (cal_bias),
		.band_out      (osc_band),
		.core_out      (osc_core),
		.bias_out      (osc_bias),
		.core_code_bad (test_core_code_bad)
	);

endmodule : vccr_regs

// ### verilog/vccr_test_override.sv
/*
 * Test-mode override of band, core and bias toward the oscillator.
 * Assumes the calibration machine supplies the normal-mode values.
 */
module vccr_test_override
	import vccr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 test_mode_en,
	input  wire logic [7:0]           test_band,
	input  wire logic [W_CORE-1:0]    test_core,
	input  wire logic [W_BIAS-1:0]    test_bias,
	input  wire logic [7:0]           cal_band,
	input  wire logic [W_CORE-1:0]    cal_core,
	input  wire logic [W_BIAS-1:0]    cal_bias,
	output logic [7:0]                band_out,
	output logic [W_CORE-1:0]         core_out,
	output logic [W_BIAS-1:0]         bias_out,
	output logic                      core_code_bad
);
	import vccr_pkg::*;

	logic bad;

	assign bad = test_mode_en && !$onehot0(test_core);

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			band_out      <= '0;
			core_out      <= '0;
			bias_out      <= '0;
			core_code_bad <= 1'b0;
		end else begin
			core_code_bad <= bad;
			if (test_mode_en) begin
				band_out <= test_band;
				core_out <= bad ? '0 : test_core;
				bias_out <= test_bias;
			end else begin
				band_out <= cal_band;
				core_out <= cal_core;
				bias_out <= cal_bias;
			end
		end
	end

endmodule : vccr_test_override
